// *** pkg/acs_pkg.sv ***
package acs_pkg;

    // ==========================================================
    // Register layout
    // ==========================================================
    localparam logic [7:0] ACS_CTRL_ADDR = 8'h39;
    localparam logic [15:0] ACS_CTRL_RESET = 16'h0000;
    localparam int ACS_RDY_MODE_BIT = 13;
    localparam int ACS_RATE_LSB = 10;
    localparam int ACS_SEQ_LSB = 8;
    localparam int ACS_NUM_SLOTS = 8;
    localparam logic [15:0] ACS_CTRL_WMASK = 16'h3FFF;

    typedef enum logic [1:0]
    {
        ACS_CMD_STOP_UP = 2'h0,
        ACS_CMD_SINGLE = 2'h1,
        ACS_CMD_CONT = 2'h2,
        ACS_CMD_STOP_DOWN = 2'h3
    } acs_cmd_t;

    localparam logic [2:0] ACS_RATE_20 = 3'h0;
    localparam logic [2:0] ACS_RATE_1200 = 3'h2;
    localparam logic [2:0] ACS_RATE_4800 = 3'h3;
    localparam logic [2:0] ACS_RATE_9600 = 3'h4;
    localparam logic [2:0] ACS_RATE_19200 = 3'h5;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int ACS_CLK_MHZ = 125;
    localparam int ACS_PWRUP_US = 100;
    localparam int ACS_RDY_US = 25;
    localparam int ACS_PWRUP_CYC = ACS_PWRUP_US * ACS_CLK_MHZ;
    localparam int ACS_RDY_CYC = ACS_RDY_US * ACS_CLK_MHZ;

endpackage

// *** rtl/acs_sequencer.sv ***
`timescale 1ns/1ns
module acs_sequencer
    import acs_pkg::*;
#(
    parameter int PWRUP_CYCLES = ACS_PWRUP_CYC,
    parameter int RDY_CYCLES = ACS_RDY_CYC
)
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic conv_done,
    output logic conv_start,
    output logic [2:0] conv_slot,
    output logic conv_is_diag,
    output logic [2:0] diagnostic_rate_sel,
    output logic adc_busy,
    output logic powered_down_state,
    output logic adc_ready,
    output logic last_result_update,
    output logic [7:0] result_update
);

    // ==========================================================
    // Reset release
    // ==========================================================
    logic rst_meta;
    logic rst_sync;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // ==========================================================
    // Control register
    // ==========================================================
    typedef enum logic [2:0]
    {
        ACS_ST_DOWN,
        ACS_ST_PWRUP,
        ACS_ST_IDLE,
        ACS_ST_PICK,
        ACS_ST_CONV
    } acs_state_t;

    acs_state_t state;
    acs_state_t next_state;
    logic [15:0] ctrl;
    logic [7:0] run_en;
    logic run_cont;
    logic [7:0] done_mask;
    logic [2:0] slot;
    logic [7:0] seq_done;
    logic [31:0] pwr_cnt;
    logic [31:0] rdy_cnt;
    logic rdy_hold;
    logic ctrl_write;
    logic pending;
    logic [1:0] pending_cmd;

    function automatic logic [2:0] acs_rate_decode(input logic [2:0] code);
        logic [2:0] r;
        r = ACS_RATE_20;
        if (code == ACS_RATE_1200 || code == ACS_RATE_4800 ||
            code == ACS_RATE_9600 || code == ACS_RATE_19200)
            r = code;
        return r;
    endfunction

    function automatic logic [2:0] acs_first(input logic [7:0] m);
        logic [2:0] f;
        f = 3'h0;
        for (int i = ACS_NUM_SLOTS - 1; i >= 0; i--)
            if (m[i])
                f = 3'(i);
        return f;
    endfunction

    function automatic logic [3:0] acs_count(input logic [7:0] m);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < ACS_NUM_SLOTS; i++)
            c = c + 4'(m[i]);
        return c;
    endfunction

    assign ctrl_write = reg_write && (reg_addr == ACS_CTRL_ADDR);

    wire [1:0] cur_cmd = ctrl[ACS_SEQ_LSB +: 2];
    wire rdy_mode = ctrl[ACS_RDY_MODE_BIT];
    // Slots 0..3 are channels, 4..7 diagnostics: lowest index first
    wire [7:0] remaining = run_en & ~done_mask;
    wire [2:0] next_slot = acs_first(remaining);
    wire last_conv = (remaining & ~(8'h01 << slot)) == 8'h00;
    wire single_one = acs_count(run_en) == 4'h1;
    wire [2:0] sel_rate = acs_rate_decode(ctrl[ACS_RATE_LSB +: 3]);
    wire conv_fin = (state == ACS_ST_CONV) && conv_done;
    wire seq_fin = conv_fin && last_conv;
    wire start_req = pending && ctrl[7:0] != 8'h00 &&
        (pending_cmd == ACS_CMD_SINGLE || pending_cmd == ACS_CMD_CONT);
    wire pwr_done = pwr_cnt == 32'(PWRUP_CYCLES - 1);

    always_ff @(posedge clock or negedge rst_sync)
    begin
        if (!rst_sync)
            ctrl <= ACS_CTRL_RESET;
        else if (ctrl_write)
            ctrl <= reg_wdata & ACS_CTRL_WMASK;
    end

    // A start command outlives the power-up wait; others apply when safe
    always_ff @(posedge clock or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            pending <= 1'b0;
            pending_cmd <= 2'h0;
        end
        else if (ctrl_write)
        begin
            pending <= 1'b1;
            pending_cmd <= reg_wdata[ACS_SEQ_LSB +: 2];
        end
        else if (state == ACS_ST_IDLE || (state == ACS_ST_DOWN &&
                 pending_cmd != ACS_CMD_SINGLE && pending_cmd != ACS_CMD_CONT))
            pending <= 1'b0;
    end

    // ==========================================================
    // Sequencer
    // ==========================================================
    always_comb
    begin
        next_state = state;
        unique case (state)
            ACS_ST_DOWN:
                if (pending && pending_cmd != ACS_CMD_STOP_DOWN)
                    next_state = ACS_ST_PWRUP;
            ACS_ST_PWRUP:
                if (pwr_done)
                    next_state = ACS_ST_IDLE;
            ACS_ST_IDLE:
                if (pending && pending_cmd == ACS_CMD_STOP_DOWN)
                    next_state = ACS_ST_DOWN;
                else if (start_req)
                    next_state = ACS_ST_PICK;
            ACS_ST_PICK:
                next_state = ACS_ST_CONV;
            ACS_ST_CONV:
                if (seq_fin)
                begin
                    if (run_cont && cur_cmd == ACS_CMD_CONT)
                        next_state = ACS_ST_PICK;
                    else if (cur_cmd == ACS_CMD_STOP_DOWN)
                        next_state = ACS_ST_DOWN;
                    else
                        next_state = ACS_ST_IDLE;
                end
                else if (conv_fin)
                    next_state = ACS_ST_PICK;
        endcase
    end

    always_ff @(posedge clock or negedge rst_sync)
    begin
        if (!rst_sync)
            state <= ACS_ST_DOWN;
        else
            state <= next_state;
    end

    // Power-up wait counter
    always_ff @(posedge clock or negedge rst_sync)
    begin
        if (!rst_sync)
            pwr_cnt <= 32'h0;
        else if (state == ACS_ST_PWRUP)
            pwr_cnt <= pwr_cnt + 32'h1;
        else
            pwr_cnt <= 32'h0;
    end

    // Enables are latched at sequence start, so host edits mid-run wait
    always_ff @(posedge clock or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            run_en <= 8'h00;
            run_cont <= 1'b0;
            done_mask <= 8'h00;
            slot <= 3'h0;
            seq_done <= 8'h00;
        end
        else if (state == ACS_ST_IDLE && next_state == ACS_ST_PICK)
        begin
            run_en <= ctrl[7:0];
            run_cont <= pending_cmd == ACS_CMD_CONT;
            done_mask <= 8'h00;
            seq_done <= 8'h00;
        end
        else if (state == ACS_ST_PICK)
            slot <= next_slot;
        else if (conv_fin)
        begin
            done_mask <= seq_fin ? 8'h00 : done_mask | (8'h01 << slot);
            seq_done <= seq_done | (8'h01 << slot);
            if (seq_fin)
                seq_done <= 8'h00;
        end
    end

    // ==========================================================
    // Converter strobes and result updates
    // ==========================================================
    always_ff @(posedge clock or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            conv_start <= 1'b0;
            conv_slot <= 3'h0;
            conv_is_diag <= 1'b0;
            diagnostic_rate_sel <= ACS_RATE_20;
            last_result_update <= 1'b0;
            result_update <= 8'h00;
        end
        else
        begin
            conv_start <= state == ACS_ST_PICK;
            conv_slot <= next_slot;
            conv_is_diag <= next_slot[2];
            diagnostic_rate_sel <= sel_rate;
            last_result_update <= conv_fin;
            if (conv_fin && rdy_mode)
                result_update <= 8'h01 << slot;
            else if (seq_fin)
                result_update <= seq_done | (8'h01 << slot);
            else
                result_update <= 8'h00;
        end
    end

    // ==========================================================
    // Ready pin
    // ==========================================================
    wire rdy_event = rdy_mode ? conv_fin : seq_fin;
    // Mode 0 single and mode 1 single with one slot hold until the next write
    wire hold_sel = !run_cont && (!rdy_mode || single_one);
    always_ff @(posedge clock or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            adc_ready <= 1'b0;
            rdy_hold <= 1'b0;
            rdy_cnt <= 32'h0;
        end
        else if (rdy_event)
        begin
            adc_ready <= 1'b1;
            rdy_hold <= hold_sel;
            rdy_cnt <= 32'h0;
        end
        else if (adc_ready && rdy_hold)
        begin
            if (ctrl_write)
                adc_ready <= 1'b0;
        end
        else if (adc_ready)
        begin
            rdy_cnt <= rdy_cnt + 32'h1;
            if (rdy_cnt == 32'(RDY_CYCLES - 1))
                adc_ready <= 1'b0;
        end
    end

    // ==========================================================
    // Status
    // ==========================================================
    always_ff @(posedge clock or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            adc_busy <= 1'b0;
            powered_down_state <= 1'b1;
            reg_rdata <= ACS_CTRL_RESET;
        end
        else
        begin
            adc_busy <= (next_state != ACS_ST_IDLE &&
                         next_state != ACS_ST_DOWN) ||
                        (next_state == ACS_ST_IDLE && start_req);
            powered_down_state <= next_state == ACS_ST_DOWN;
            reg_rdata <= (reg_addr == ACS_CTRL_ADDR) ? ctrl : 16'h0000;
        end
    end

endmodule // acs_sequencer

// *** tb/acs_conv_model.sv ***
`timescale 1ns/1ns
module acs_conv_model
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic conv_start,
    input wire logic [7:0] delay,
    output logic conv_done
);
    // Finish only follows a start, never spontaneously
    int cnt;
    always @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt <= 0;
            conv_done <= 1'b0;
        end
        else
        begin
            conv_done <= (cnt == 1);
            if (conv_start)
                cnt <= delay;
            else if (cnt > 0)
                cnt <= cnt - 1;
        end
    end
endmodule // acs_conv_model

// *** tb/acs_sequencer_chk.sv ***
`timescale 1ns/1ns
module acs_sequencer_chk
    import acs_pkg::*;
#(
    parameter int PWRUP_CYCLES = 20,
    parameter int RDY_CYCLES = 10
)
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic conv_done,
    input wire logic conv_start,
    input wire logic [2:0] conv_slot,
    input wire logic conv_is_diag,
    input wire logic [2:0] diagnostic_rate_sel,
    input wire logic adc_busy,
    input wire logic powered_down_state,
    input wire logic adc_ready,
    input wire logic last_result_update,
    input wire logic [7:0] result_update
);
    // ====================
    // Shadow of the control register
    logic [15:0] cfg;
    wire wr_hit = reg_write && reg_addr == ACS_CTRL_ADDR;
    wire mode1 = cfg[13];
    wire [1:0] seq = cfg[9:8];
    wire [2:0] cr = cfg[12:10];
    wire [2:0] exp_rate = (cr >= 3'h2 && cr <= 3'h5) ? cr : 3'h0;
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            cfg <= 16'h0000;
        else if (wr_hit)
            cfg <= reg_wdata;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // ====================
    // Properties
    chk_rate_decode:
    assert property ($past(wr_hit, 2) |-> diagnostic_rate_sel == exp_rate)
    else $error("rate select mismatch");
    chk_pwrup_busy:
    assert property (wr_hit && reg_wdata[9:8] != 2'h3 && powered_down_state
        && !adc_busy |-> ##[1:2] (adc_busy && !conv_start)[*8])
    else $error("power-up wait too short");
    chk_result_each:
    assert property (conv_done && mode1 |=>
        last_result_update && $onehot(result_update))
    else $error("results not updated after conversion");
    chk_ready_each:
    assert property (conv_done && mode1 |=> adc_ready)
    else $error("ready missing after conversion");
    chk_slot_enabled:
    assert property (conv_start |->
        cfg[conv_slot] && conv_is_diag == conv_slot[2])
    else $error("start on a disabled slot");
    chk_ready_release:
    assert property ($rose(adc_ready) && mode1 && (seq == 2'h2 ||
        (seq == 2'h1 && !$onehot(cfg[7:0])))
        |-> ##8 adc_ready ##[1:3] !adc_ready)
    else $error("ready pulse width wrong");
    chk_ready_hold:
    assert property ($rose(adc_ready) && mode1 && seq == 2'h1
        && $onehot(cfg[7:0]) |-> adc_ready[*8])
    else $error("ready dropped before write");
    chk_single_idle:
    assert property ($rose(adc_ready) && !mode1 && seq == 2'h1
        |-> ##[0:2] !adc_busy)
    else $error("single sequence did not end");
    chk_down_quiet:
    assert property (powered_down_state |-> !conv_start)
    else $error("conversion while powered down");
endmodule // acs_sequencer_chk

bind acs_sequencer acs_sequencer_chk #(.PWRUP_CYCLES(PWRUP_CYCLES),
    .RDY_CYCLES(RDY_CYCLES)) u_acs_sequencer_chk (.clock, .reset_n,
    .reg_write, .reg_addr, .reg_wdata, .conv_done, .conv_start, .conv_slot,
    .conv_is_diag, .diagnostic_rate_sel, .adc_busy, .powered_down_state,
    .adc_ready, .last_result_update, .result_update);

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    localparam int PW = 20;
    logic clock, reset_n, reg_write, conv_done, conv_start, conv_is_diag;
    logic adc_busy, powered_down_state, adc_ready, last_result_update, rq;
    logic [7:0] reg_addr, result_update, upd, delay;
    logic [15:0] reg_wdata, reg_rdata;
    logic [2:0] conv_slot, diagnostic_rate_sel;
    logic [2:0] slots[$];
    int n_errors, compares, rises, i, j, n;
    acs_sequencer #(.PWRUP_CYCLES(PW), .RDY_CYCLES(10)) u_acs_sequencer (
        .clock, .reset_n, .reg_write, .reg_addr, .reg_wdata, .reg_rdata,
        .conv_done, .conv_start, .conv_slot, .conv_is_diag,
        .diagnostic_rate_sel, .adc_busy, .powered_down_state, .adc_ready,
        .last_result_update, .result_update);
    acs_conv_model u_acs_conv_model (.clock, .reset_n, .conv_start, .delay,
        .conv_done);
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock)
    begin
        rq <= adc_ready;
        upd <= upd | result_update;
        if (conv_start)
            slots.push_back(conv_slot);
        if (adc_ready && !rq)
            rises <= rises + 1;
    end
    // ====================
    // Tasks
    task cmp(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task wr(input logic [15:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= 8'h39;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clock);
        reg_addr <= a;
        repeat (2) @(posedge clock);
        #1 cmp(reg_rdata, e);
    endtask
    task wt(input logic lv);
        #1;
        for (n = 0; n < 400 && adc_busy !== lv; n++)
            @(posedge clock) #1;
        cmp(adc_busy, lv);
    endtask
    // Single sequence, then slot order against the enable mask
    task run(input logic [15:0] c);
        repeat (20) @(posedge clock);
        #1;
        slots = {};
        upd = 8'h00;
        rises = 0;
        wr(c);
        wt(1);
        wt(0);
        @(posedge clock) #1;
        cmp(upd, c[7:0]);
        j = 0;
        for (i = 0; i < 8; i++)
            if (c[i])
            begin
                cmp(slots[j], i);
                j++;
            end
        cmp(slots.size(), j);
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge clock);
        n_errors++;
        conclude;
    end
    // ====================
    // Tests
    initial
    begin
        {reset_n, reg_write, reg_addr, reg_wdata, delay} = {2'h0, 8'h39,
            16'h0000, 8'h0F};
        {n_errors, compares, upd, rises} = 0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        #1 cmp(powered_down_state, 1);
        rd(8'h39, 16'h0000);
        rd(8'h3A, 16'h0000);
        $display("reset test done");
        wr(16'hDC00);
        wt(1);
        wt(0);
        cmp(n > PW - 4 && n < PW + 3, 1);
        cmp(powered_down_state, 0);
        rd(8'h39, 16'h1C00);
        for (i = 0; i < 8; i++)
        begin
            wr({3'h0, i[2:0], 10'h000});
            repeat (2) @(posedge clock);
            #1 cmp(diagnostic_rate_sel, (i > 1 && i < 6) ? i : 0);
        end
        $display("power-up and rate test done");
        run(16'h2181);
        cmp(rises, 2);
        run(16'h2104);
        repeat (30) @(posedge clock);
        #1 cmp(adc_ready, 1);
        wr(16'h2004);
        repeat (3) @(posedge clock);
        #1 cmp(adc_ready, 0);
        delay <= 8'h03;
        repeat (2)
        begin
            run(16'h010F);
            cmp(rises, 1);
        end
        $display("single test done");
        delay <= 8'h0F;
        for (i = 0; i < 2; i++)
        begin
            slots = {};
            wr(16'h2203);
            repeat (120) @(posedge clock);
            wr(i ? 16'h2303 : 16'h2003);
            wt(0);
            cmp(slots.size() > 4, 1);
            cmp(slots.size() % 2, 0);
            cmp(slots[$], 1);
            cmp(powered_down_state, i);
        end
        run(16'h0180);
        cmp(powered_down_state, 0);
        $display("continuous test done");
        conclude;
    end
endmodule // tb_top
